// [rtl/scg_sleep_gate.sv]
/*
 * Clock gating control: run, sleep and deep-sleep gating registers, the
 * selection of the one in force, per-unit clock enables, access faults on
 * unclocked units and a fault interrupt. Assumes unit_access strobes are
 * synchronous one-cycle pulses and power-state requests are synchronous levels.
 */
// Behaviour
// R1 - a set gating bit clocks its unit; a clear bit leaves it unclocked
// R2 - an access to an unclocked unit is answered with a fault
// R3 - gating bits reset to zero; printed reset word is 0x00000040 (the code masks bit 6 and resets to 0x00000000)
// R4 - run, sleep and deep-sleep registers exist; the one for the state applies
// R5 - sleep and deep-sleep gating apply only while auto gating is enabled
// R6 - bit 3 gates the watchdog, read-write, resets to zero
// R7 - bits 9:8 pick adc rate: 1 is 250k, 0 is 125k, reset zero
// R8 - the adc rate can never be set above the supported maximum
// R9 - reserved bits read zero and ignore writes
// R10 - bit 20 gates pwm, bit 16 gates adc 0, both reset to zero
`timescale 1ns/10ps
module scg_sleep_gate
   import scg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [SCG_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SCG_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire scg_pkg::scg_units_t unit_access,
   output scg_pkg::scg_units_t unit_clk_en,
   output scg_pkg::scg_units_t unit_fault,
   output logic [1:0] adc_sample_rate_sel,
   output logic irq
);
   import scg_pkg::*;

   scg_wreq_t wreq;
   logic wr_err;
   logic [SCG_ADDR_W-1:0] rd_addr;
   logic [31:0] rd_word;
   logic rd_err;
   logic [31:0] gate_reg [3];
   logic auto_gating_enable;
   scg_units_t status;
   scg_units_t mask;
   scg_units_t fault_ev;
   scg_units_t stat_clr;
   scg_pstate_t power_state;
   scg_pstate_t next_power_state;
   scg_gate_t sel_gate;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic hit(input logic [SCG_ADDR_W-1:0] addr, input logic [SCG_ADDR_W-1:0] off);
      return addr[SCG_ADDR_W-1:2] == off[SCG_ADDR_W-1:2];
   endfunction : hit

   function automatic logic [SCG_ADDR_W-1:0] gate_off(input int idx);
      logic [SCG_ADDR_W-1:0] off;
      case (idx)
         0: off = SCG_OFF_RUN_GATE;
         1: off = SCG_OFF_SLEEP_GATE;
         default: off = SCG_OFF_DEEP_GATE;
      endcase
      return off;
   endfunction : gate_off

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] w;
      w = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            w[8*b +: 8] = data[8*b +: 8];
         end
      end
      return w;
   endfunction : merge

   // an out-of-range rate is pulled down to the maximum instead of refused,
   // so a careless write can never overdrive the converter
   function automatic logic [31:0] gate_write(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] w;
      w = merge(old, data, strb) & SCG_GATE_WMASK; // R9
      if (w[SCG_BIT_RATE_LSB +: 2] > SCG_RATE_MAX) begin
         w[SCG_BIT_RATE_LSB +: 2] = SCG_RATE_MAX; // R8
      end
      return w;
   endfunction : gate_write

   function automatic scg_gate_t gate_view(input logic [31:0] w);
      scg_gate_t g;
      g.units.pwm = w[SCG_BIT_PWM]; // R10
      g.units.adc0 = w[SCG_BIT_ADC0]; // R10
      g.units.wdt = w[SCG_BIT_WDT]; // R6
      g.rate = w[SCG_BIT_RATE_LSB +: 2]; // R7
      return g;
   endfunction : gate_view

   function automatic logic [31:0] gate_word(input scg_gate_t g);
      logic [31:0] w;
      w = '0;
      w[SCG_BIT_PWM] = g.units.pwm;
      w[SCG_BIT_ADC0] = g.units.adc0;
      w[SCG_BIT_WDT] = g.units.wdt;
      w[SCG_BIT_RATE_LSB +: 2] = g.rate;
      return w;
   endfunction : gate_word

   ////////////////////////////////////////////////////////////////////////////
   scg_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wreq(wreq),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_word(rd_word),
      .rd_err(rd_err)
   );

   ////////////////////////////////////////////////////////////////////////////
   // gating registers: index 0 run, 1 sleep, 2 deep sleep
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 3; i++) begin
            gate_reg[i] <= SCG_GATE_RESET & SCG_GATE_WMASK; // R3
         end
      end else if (wreq.en) begin
         for (int i = 0; i < 3; i++) begin
            if (hit(wreq.addr, gate_off(i))) begin
               gate_reg[i] <= gate_write(gate_reg[i], wreq.data, wreq.strb); // R4
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         auto_gating_enable <= SCG_CFG_RESET[SCG_BIT_AUTO_GATE];
      end else if (wreq.en && hit(wreq.addr, SCG_OFF_RUN_CFG) && wreq.strb[0]) begin
         auto_gating_enable <= wreq.data[SCG_BIT_AUTO_GATE];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask <= '0;
      end else if (wreq.en && hit(wreq.addr, SCG_OFF_IRQ_MASK) && wreq.strb[0]) begin
         mask <= wreq.data[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power state follows the system requests; deep sleep outranks sleep
   always_comb begin
      case (power_state)
         SCG_PS_RUN, SCG_PS_SLEEP, SCG_PS_DEEP: begin
            if (deep_sleep_req) begin
               next_power_state = SCG_PS_DEEP;
            end else if (sleep_req) begin
               next_power_state = SCG_PS_SLEEP;
            end else begin
               next_power_state = SCG_PS_RUN;
            end
         end
         default: next_power_state = SCG_PS_RUN;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_state <= SCG_PS_RUN;
      end else begin
         power_state <= next_power_state;
      end
   end

   always_comb begin
      sel_gate = gate_view(gate_reg[0]);
      if (auto_gating_enable) begin // R5
         case (power_state)
            SCG_PS_SLEEP: sel_gate = gate_view(gate_reg[1]); // R4
            SCG_PS_DEEP: sel_gate = gate_view(gate_reg[2]); // R4
            default: sel_gate = gate_view(gate_reg[0]);
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enables are registered so the unit gates see a glitch-free level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_clk_en <= '0; // R3
         adc_sample_rate_sel <= SCG_RATE_125K;
      end else begin
         unit_clk_en <= sel_gate.units; // R1
         adc_sample_rate_sel <= sel_gate.rate; // R7
      end
   end

   assign fault_ev = unit_access & ~unit_clk_en;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_fault <= '0;
      end else begin
         unit_fault <= fault_ev; // R2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault status: write one to clear, a new fault wins over the clear
   assign stat_clr = (wreq.en && hit(wreq.addr, SCG_OFF_IRQ_STAT) && wreq.strb[0]) ? wreq.data[2:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
      end else begin
         status <= (status & ~stat_clr) | fault_ev; // R2
      end
   end

   assign irq = |(status & mask);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd_word = '0;
      rd_err = 1'b0;
      if (hit(rd_addr, SCG_OFF_RUN_GATE)) begin
         rd_word = gate_reg[0];
      end else if (hit(rd_addr, SCG_OFF_SLEEP_GATE)) begin
         rd_word = gate_reg[1];
      end else if (hit(rd_addr, SCG_OFF_DEEP_GATE)) begin
         rd_word = gate_reg[2];
      end else if (hit(rd_addr, SCG_OFF_RUN_CFG)) begin
         rd_word[SCG_BIT_AUTO_GATE] = auto_gating_enable;
      end else if (hit(rd_addr, SCG_OFF_ACTIVE)) begin
         rd_word = gate_word({unit_clk_en, adc_sample_rate_sel});
         rd_word[SCG_BIT_PSTATE_LSB +: 2] = 2'(power_state);
      end else if (hit(rd_addr, SCG_OFF_IRQ_STAT)) begin
         rd_word[2:0] = status;
      end else if (hit(rd_addr, SCG_OFF_IRQ_MASK)) begin
         rd_word[2:0] = mask;
      end else begin
         rd_err = 1'b1;
      end
   end

   // the active-state word is read-only; writes to it are dropped with OKAY
   assign wr_err = !(hit(wreq.addr, SCG_OFF_RUN_GATE) || hit(wreq.addr, SCG_OFF_SLEEP_GATE) ||
                     hit(wreq.addr, SCG_OFF_DEEP_GATE) || hit(wreq.addr, SCG_OFF_RUN_CFG) ||
                     hit(wreq.addr, SCG_OFF_ACTIVE) || hit(wreq.addr, SCG_OFF_IRQ_STAT) ||
                     hit(wreq.addr, SCG_OFF_IRQ_MASK));

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_clk_follow;
      1'b1 |=> unit_clk_en == $past(sel_gate.units);
   endproperty
   a_clk_follow: assert property (p_clk_follow) else $error("clock enable does not follow gating"); // R1

   property p_wdt_fault;
      unit_access.wdt && !unit_clk_en.wdt |=> unit_fault.wdt && status.wdt;
   endproperty
   a_wdt_fault: assert property (p_wdt_fault) else $error("watchdog access while gated not faulted"); // R2

   property p_pwm_nofault;
      unit_access.pwm && unit_clk_en.pwm |=> !unit_fault.pwm;
   endproperty
   a_pwm_nofault: assert property (p_pwm_nofault) else $error("clocked pwm access faulted"); // R10

   property p_reset_vals;
      $rose(aresetn) |-> gate_reg[1] == 32'h00000000 && unit_clk_en == '0 && !irq;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("gating not cleared after reset"); // R3

   property p_deep_sel;
      auto_gating_enable && power_state == SCG_PS_DEEP
         |=> unit_clk_en == {$past(gate_reg[2][SCG_BIT_PWM]), $past(gate_reg[2][SCG_BIT_ADC0]),
                             $past(gate_reg[2][SCG_BIT_WDT])};
   endproperty
   a_deep_sel: assert property (p_deep_sel) else $error("deep sleep gating not selected"); // R4

   property p_auto_off;
      !auto_gating_enable && sleep_req
         |=> unit_clk_en == {$past(gate_reg[0][SCG_BIT_PWM]), $past(gate_reg[0][SCG_BIT_ADC0]),
                             $past(gate_reg[0][SCG_BIT_WDT])};
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("sleep gating used without auto gating"); // R5

   property p_rate_max;
      adc_sample_rate_sel <= SCG_RATE_MAX && gate_reg[1][SCG_BIT_RATE_LSB +: 2] <= SCG_RATE_MAX;
   endproperty
   a_rate_max: assert property (p_rate_max) else $error("adc rate above maximum"); // R8

   property p_rate_clamp;
      wreq.en && hit(wreq.addr, SCG_OFF_SLEEP_GATE) && wreq.strb[1] && wreq.data[9:8] == 2'h3
         |=> gate_reg[1][9:8] == SCG_RATE_250K;
   endproperty
   a_rate_clamp: assert property (p_rate_clamp) else $error("oversized rate not clamped"); // R7

   property p_reserved_zero;
      hit(rd_addr, SCG_OFF_SLEEP_GATE) |-> (rd_word & ~SCG_GATE_WMASK) == 32'h00000000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // R9

   property p_wdt_bit;
      wreq.en && hit(wreq.addr, SCG_OFF_SLEEP_GATE) && wreq.strb[0] |=> gate_reg[1][3] == $past(wreq.data[3]);
   endproperty
   a_wdt_bit: assert property (p_wdt_bit) else $error("watchdog gating bit not written"); // R6

   property p_set_wins;
      fault_ev.adc0 && stat_clr.adc0 |=> status.adc0;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("fault lost to clear"); // R2

   property p_bresp_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped early");

   c_wdt_fault: cover property (unit_access.wdt && !unit_clk_en.wdt ##1 unit_fault.wdt);
   c_sleep_gating: cover property (auto_gating_enable && power_state == SCG_PS_SLEEP && unit_clk_en.pwm);
   c_irq: cover property ($rose(irq));
   c_clamp: cover property (wreq.en && hit(wreq.addr, SCG_OFF_SLEEP_GATE) && wreq.data[9:8] == 2'h3);

endmodule : scg_sleep_gate

// [rtl/scg_pkg.sv]
/*
 * Package of the sleep-mode clock gating block: register offsets, field
 * positions, reset values, carrier types and the power-state enumeration.
 * Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
 */
package scg_pkg;

   localparam int SCG_ADDR_W = 12;

   // register byte offsets
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_RUN_GATE = 12'h100;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_SLEEP_GATE = 12'h110;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_DEEP_GATE = 12'h120;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_RUN_CFG = 12'h130;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_ACTIVE = 12'h134;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_IRQ_STAT = 12'h140;
   localparam logic [SCG_ADDR_W-1:0] SCG_OFF_IRQ_MASK = 12'h144;

   // gating, run-config and active-state register layout
   localparam int SCG_BIT_WDT = 3;
   localparam int SCG_BIT_RATE_LSB = 8;
   localparam int SCG_BIT_ADC0 = 16;
   localparam int SCG_BIT_PWM = 20;
   localparam int SCG_BIT_AUTO_GATE = 0;
   localparam int SCG_BIT_PSTATE_LSB = 30;
   localparam logic [31:0] SCG_GATE_RESET = 32'h00000040;
   localparam logic [31:0] SCG_GATE_WMASK = 32'h00110308;
   localparam logic [31:0] SCG_CFG_RESET = 32'h00000000;

   // adc sample-rate codes
   localparam logic [1:0] SCG_RATE_125K = 2'h0;
   localparam logic [1:0] SCG_RATE_250K = 2'h1;
   localparam logic [1:0] SCG_RATE_MAX = SCG_RATE_250K;

   localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
   localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic pwm;
      logic adc0;
      logic wdt;
   } scg_units_t;

   typedef struct packed {
      scg_units_t units;
      logic [1:0] rate;
   } scg_gate_t;

   typedef struct packed {
      logic en;
      logic [SCG_ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } scg_wreq_t;

   typedef enum {SCG_PS_RUN, SCG_PS_SLEEP, SCG_PS_DEEP} scg_pstate_t;

endpackage : scg_pkg

// [rtl/scg_axil_slave.sv]
/*
 * AXI4-Lite slave front end: takes write address and data in either order,
 * issues one write strobe per transfer, and answers reads one cycle after the
 * address is taken. Assumes the register file decodes combinationally.
 */
`timescale 1ns/10ps
module scg_axil_slave
   import scg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [SCG_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SCG_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output scg_pkg::scg_wreq_t wreq,
   input wire logic wr_err,
   output logic [SCG_ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_word,
   input wire logic rd_err
);
   import scg_pkg::*;

   logic aw_full;
   logic w_full;
   logic [SCG_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // write path: one slot per channel, held until the write is done
   assign s_axi_awready = !aw_full;
   assign s_axi_wready = !w_full;
   assign wreq.en = aw_full && w_full && !s_axi_bvalid;
   assign wreq.addr = aw_addr;
   assign wreq.data = w_data;
   assign wreq.strb = w_strb;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (wreq.en) begin
         aw_full <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (wreq.en) begin
         w_full <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SCG_RESP_OKAY;
      end else if (wreq.en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? SCG_RESP_SLVERR : SCG_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: data captured at the address handshake
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_addr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SCG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_err ? SCG_RESP_SLVERR : SCG_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : scg_axil_slave

// [bench/scg_unit_model.sv]
/*
 * Peripheral units behind the gated clocks: each pulses an access when told
 * and keeps a sticky log of the bus faults it got back.
 * Assumes go changes just after a rising edge of aclk.
 */
`timescale 1ns/10ps
module scg_unit_model
   import scg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire scg_pkg::scg_units_t go,
   input wire scg_pkg::scg_units_t unit_fault,
   output scg_pkg::scg_units_t unit_access,
   output scg_pkg::scg_units_t fault_log
);
   import scg_pkg::*;

   // one-cycle access pulse per go cycle
   always_ff @(posedge aclk) begin
      unit_access <= aresetn ? go : '0;
   end

   // sticky so the bench need not catch the one-cycle fault pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_log <= '0;
      end else begin
         fault_log <= fault_log | unit_fault;
      end
   end
endmodule : scg_unit_model

// [bench/scg_sleep_gate_tb_top.sv]
/*
 * Self-checking bench of the sleep gating block: register rows, state
 * selection, faults, interrupt and reset. Assumes the package and design.
 */
`timescale 1ns/10ps
module scg_sleep_gate_tb_top;
   import scg_pkg::*;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] w;
      logic [31:0] r;
      logic [1:0] s;
   } scg_row_t;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq, sleep_req, deep_sleep_req;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rate, rs;
   scg_units_t acc, clk_en, fault, go, flog;
   int failures, n_tests;
   scg_row_t rows[7] = '{
      '{12'h110, 32'hffffffff, 32'h00110108, 2'h0},
      '{12'h110, 32'h00000200, 32'h00000100, 2'h0},
      '{12'h110, 32'h00100008, 32'h00100008, 2'h0},
      '{12'h100, 32'h00010100, 32'h00010100, 2'h0},
      '{12'h120, 32'h00000008, 32'h00000008, 2'h0},
      '{12'h200, 32'hffffffff, 32'h00000000, 2'h2},
      '{12'h144, 32'h00000007, 32'h00000007, 2'h0}};

   scg_sleep_gate i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_req(sleep_req),
      .deep_sleep_req(deep_sleep_req), .unit_access(acc), .unit_clk_en(clk_en), .unit_fault(fault),
      .adc_sample_rate_sel(rate), .irq(irq));
   scg_unit_model i_units (.aclk(aclk), .aresetn(aresetn), .go(go), .unit_fault(fault),
      .unit_access(acc), .fault_log(flog));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("failures %0d of n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   // ready is combinational, so handshakes are judged at the falling edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
   endtask : wr

   task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ar = arvalid & arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
      end while (!v);
   endtask : rdr

   // two edges from a state request to the enables
   task automatic settle;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
   endtask : settle

   task automatic poke(input scg_units_t u);
      @(posedge aclk);
      go <= u;
      @(posedge aclk);
      go <= '0;
      settle();
   endtask : poke

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   initial begin
      repeat (3000) @(posedge aclk);
      failures++;
      end_sim();
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, arvalid, sleep_req, deep_sleep_req} = '0;
      {bready, rready} = 2'b11;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      go = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rdr(12'h100 + 12'(i * 16), rd, rs);
         chk(rd, 32'h0);
      end
      chk({27'h0, clk_en, irq, rate}, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, rs);
         chk(32'(rs), 32'(rows[i].s));
         rdr(rows[i].a, rd, rs);
         chk(rd, rows[i].r);
         chk(32'(rs), 32'(rows[i].s));
      end
      @(posedge aclk);
      sleep_req <= 1'b1;
      settle();
      chk({27'h0, clk_en, rate}, 32'h9);
      wr(SCG_OFF_RUN_CFG, 32'h1, rs);
      settle();
      chk({27'h0, clk_en, rate}, 32'h14);
      poke(3'b100);
      chk({29'h0, flog}, 32'h0);
      @(posedge aclk);
      deep_sleep_req <= 1'b1;
      settle();
      chk({29'h0, clk_en}, 32'h1);
      wr(SCG_OFF_ACTIVE, 32'h0, rs);
      rdr(SCG_OFF_ACTIVE, rd, rs);
      chk(rd, 32'h80000008);
      poke(3'b101);
      chk({29'h0, flog}, 32'h4);
      chk(32'(irq), 32'h1);
      wr(SCG_OFF_IRQ_MASK, 32'h0, rs);
      @(negedge aclk);
      chk(32'(irq), 32'h0);
      poke(3'b010);
      chk({29'h0, flog}, 32'h6);
      rdr(SCG_OFF_IRQ_STAT, rd, rs);
      chk(rd, 32'h6);
      wr(SCG_OFF_IRQ_MASK, 32'h2, rs);
      @(negedge aclk);
      chk(32'(irq), 32'h1);
      wr(SCG_OFF_IRQ_STAT, 32'h2, rs);
      @(negedge aclk);
      chk(32'(irq), 32'h0);
      rdr(SCG_OFF_IRQ_STAT, rd, rs);
      chk(rd, 32'h4);
      // fault lands in the very cycle its own clear is written
      fork
         wr(SCG_OFF_IRQ_STAT, 32'h2, rs);
         poke(3'b010);
      join
      rdr(SCG_OFF_IRQ_STAT, rd, rs);
      chk(rd, 32'h6);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(SCG_OFF_SLEEP_GATE, rd, rs);
      chk(rd, 32'h0);
      chk({29'h0, clk_en}, 32'h0);
      poke(3'b001);
      chk({29'h0, flog}, 32'h1);
      end_sim();
   end
endmodule : scg_sleep_gate_tb_top
